// [rtl/nau_add_if.sv]
// Adder operand and result bundle between decoder and adder
`timescale 1ns/1ps
`default_nettype none
interface nau_add_if;
    logic [3:0] a;
    logic [3:0] b;
    logic cin;
    logic [3:0] sum;
    logic cout;
    modport ctl (output a, output b, output cin, input sum, input cout);
    modport add (input a, input b, input cin, output sum, output cout);
endinterface
`default_nettype wire

// [rtl/nau_adder.sv]
// Four-bit adder with carry in and carry out
`timescale 1ns/1ps
`default_nettype none
module nau_adder
(
    nau_add_if.add bus
);
    logic [4:0] full;
    // Five-bit sum keeps carry out of bit three apart
    assign full = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
    assign bus.sum = full[3:0];
    assign bus.cout = full[4];
endmodule // nau_adder
`default_nettype wire

// [rtl/nau_cfg.svh]
// Opcode, reset value and nibble limit constants for the nibble arithmetic unit
`ifndef NAU_CFG_SVH
`define NAU_CFG_SVH
`define NAU_OP_ADD_CONST_ACC 9'h070
`define NAU_OP_ADD_CONST_ACC_MASK 9'h1f0
`define NAU_OP_ADD_MEM_ACC 9'h015
`define NAU_OP_SUB_ACC_MEM 9'h030
`define NAU_OP_INC_MEM_ACC 9'h032
`define NAU_OP_DEC_MEM_ACC 9'h007
`define NAU_OP_INC_PTR 9'h005
`define NAU_OP_DEC_PTR 9'h004
`define NAU_OP_ADD_CONST_PTR 9'h0f0
`define NAU_OP_ADD_CONST_PTR_MASK 9'h1f0
`define NAU_OP_NEGATE_ACC 9'h031
`define NAU_ACC_RST 4'h0
`define NAU_PTR_RST 4'h0
`define NAU_STATUS_RST 1'b0
`define NAU_NIB_MAX 4'hf
`endif

// [rtl/nau_pkg.sv]
// Types shared by the nibble arithmetic unit
package nau_pkg;
    typedef logic [3:0] nau_nib_t;
    typedef logic [8:0] nau_op_t;
    typedef enum logic [1:0] {NAU_DST_NONE, NAU_DST_ACC, NAU_DST_PTR} nau_dst_t;
endpackage

// [rtl/nau_unit.sv]
// Nibble arithmetic execution path
`timescale 1ns/1ps
`default_nettype none
`include "nau_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
module nau_unit
#(
    // Data path width; the nibble type fixes it at four
    parameter int NIB_W = 4,
    // Instruction word width; the opcode type fixes it at nine
    parameter int OP_W = 9
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_exec,
    input wire nau_pkg::nau_op_t i_opcode,
    input wire nau_pkg::nau_nib_t i_mem_nib,
    output logic [3:0] o_acc,
    output logic [3:0] o_ptr,
    output logic o_status,
    output logic o_done
);
    import nau_pkg::*;

    nau_add_if add_bus ();
    nau_nib_t acc_q;
    nau_nib_t ptr_q;
    logic status_q;
    logic done_q;
    nau_dst_t dst;
    logic force_one;
    logic known;
    nau_nib_t res_nib;

    //////////////////////////////////////////////////////////////////////////
    // Widths other than those of the package types cannot be served:
    // the data registers and the opcode and memory ports here are built from the package types
    if (NIB_W != $bits(nau_nib_t) || OP_W != $bits(nau_op_t))
    begin : g_bad_width
        $error("nau_unit: width parameters must match the nibble types");
    end

    //////////////////////////////////////////////////////////////////////////
    // Shared adder
    nau_adder u_adder
    (
        .bus(add_bus)
    );

    // Opcode group match with a mask
    function automatic logic op_in(input nau_op_t op, input nau_op_t base,
                                   input nau_op_t mask);
        op_in = (op & mask) == base;
    endfunction

    // Register write enable for one destination, frozen while ce is low
    function automatic logic writes_to(input logic ce, input logic ex,
                                       input nau_dst_t sel,
                                       input nau_dst_t want);
        writes_to = ce && ex && (sel == want);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Result bits copied one by one; the carry out of bit three stays
    // behind here, so no data register can ever capture it
    for (genvar i = 0; i < NIB_W; i++)
    begin : g_trunc
        assign res_nib[i] = add_bus.sum[i];
    end

    //////////////////////////////////////////////////////////////////////////
    // Operand selection per opcode
    // One adder serves every opcode, so the operands, the carry in and
    // the destination are chosen here from the opcode.
    // An opcode that matches no group leaves known low, which keeps the acc, ptr and status
    // registers unchanged and drives the completion pulse low.
    always_comb
    begin
        add_bus.a = acc_q;
        add_bus.b = 4'h0;
        add_bus.cin = 1'b0;
        dst = NAU_DST_NONE;
        force_one = 1'b0;
        known = 1'b1;
        if (op_in(i_opcode, `NAU_OP_ADD_CONST_ACC, `NAU_OP_ADD_CONST_ACC_MASK))
        begin
            add_bus.b = i_opcode[3:0];
            dst = NAU_DST_ACC;
        end
        else if (op_in(i_opcode, `NAU_OP_ADD_CONST_PTR,
                       `NAU_OP_ADD_CONST_PTR_MASK))
        begin
            add_bus.a = ptr_q;
            add_bus.b = i_opcode[3:0];
            dst = NAU_DST_PTR;
            force_one = 1'b1;
        end
        else if (i_opcode == `NAU_OP_ADD_MEM_ACC)
        begin
            add_bus.b = i_mem_nib;
            dst = NAU_DST_ACC;
        end
        else if (i_opcode == `NAU_OP_SUB_ACC_MEM)
        begin
            add_bus.a = i_mem_nib;
            add_bus.b = ~acc_q;
            add_bus.cin = 1'b1;
            dst = NAU_DST_ACC;
        end
        else if (i_opcode == `NAU_OP_INC_MEM_ACC)
        begin
            add_bus.a = i_mem_nib;
            add_bus.cin = 1'b1;
            dst = NAU_DST_ACC;
        end
        else if (i_opcode == `NAU_OP_DEC_MEM_ACC)
        begin
            add_bus.a = i_mem_nib;
            add_bus.b = `NAU_NIB_MAX;
            dst = NAU_DST_ACC;
        end
        else if (i_opcode == `NAU_OP_INC_PTR)
        begin
            add_bus.a = ptr_q;
            add_bus.cin = 1'b1;
            dst = NAU_DST_PTR;
        end
        else if (i_opcode == `NAU_OP_DEC_PTR)
        begin
            add_bus.a = ptr_q;
            add_bus.b = `NAU_NIB_MAX;
            dst = NAU_DST_PTR;
        end
        else if (i_opcode == `NAU_OP_NEGATE_ACC)
        begin
            add_bus.a = ~acc_q;
            add_bus.cin = 1'b1;
            dst = NAU_DST_ACC;
        end
        else
        begin
            known = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Accumulator takes the four-bit sum only
    // Pointer opcodes leave it alone, so a run of pointer steps keeps
    // the last accumulator result standing on the output
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            acc_q <= `NAU_ACC_RST;
        else if (writes_to(i_ce, i_exec, dst, NAU_DST_ACC))
            acc_q <= res_nib;
    end

    //////////////////////////////////////////////////////////////////////////
    // Word pointer takes the four-bit sum only
    // The caller addresses RAM with this value, so it changes only on an
    // executed pointer opcode and never on an accumulator opcode
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            ptr_q <= `NAU_PTR_RST;
        else if (writes_to(i_ce, i_exec, dst, NAU_DST_PTR))
            ptr_q <= res_nib;
    end

    //////////////////////////////////////////////////////////////////////////
    // Status gets carry out, or one for add-constant-to-pointer
    // Unknown opcodes keep the previous flag so that a stray code cannot
    // disturb a carry that a following branch still has to test
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            status_q <= `NAU_STATUS_RST;
        else if (i_ce && i_exec && known)
            status_q <= force_one | add_bus.cout;
    end

    //////////////////////////////////////////////////////////////////////////
    // One-cycle completion pulse for a recognised opcode
    // While ce is low the pulse is held like every other register
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            done_q <= 1'b0;
        else if (i_ce)
            done_q <= i_exec && known;
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the registers above
    assign o_acc = acc_q;
    assign o_ptr = ptr_q;
    assign o_status = status_q;
    assign o_done = done_q;
endmodule // nau_unit
`default_nettype wire

// [tb/nau_unit_properties.sv]
// Port checker for the nibble arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module nau_unit_properties
(
    input wire logic i_core_clk, i_rst_n, i_ce, i_exec,
    input wire nau_pkg::nau_op_t i_opcode,
    input wire nau_pkg::nau_nib_t i_mem_nib,
    input wire logic [3:0] o_acc, o_ptr,
    input wire logic o_status, o_done
);
    import nau_pkg::*;
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic g;
    nau_nib_t a_q, y_q, m_q, k_q;
    assign g = i_ce & i_exec;
    // Operands held from the taking edge
    always_ff @(posedge i_core_clk)
    begin
        {a_q, y_q, m_q, k_q} <= {o_acc, o_ptr, i_mem_nib, i_opcode[3:0]};
    end
    // Results one cycle after a taken opcode
    a_add_const: assert property (g && i_opcode[8:4] == 5'h07 |=>
        {o_status, o_acc} == a_q + k_q) else $error("add const");
    a_add_mem: assert property (g && i_opcode == 9'h015 |=>
        {o_status, o_acc} == a_q + m_q) else $error("add mem");
    a_sub_mem: assert property (g && i_opcode == 9'h030 |=>
        o_acc == m_q - a_q && o_status == (a_q <= m_q)) else $error("sub");
    a_inc_mem: assert property (g && i_opcode == 9'h032 |=>
        {o_status, o_acc} == m_q + 5'h01) else $error("inc mem");
    a_dec_mem: assert property (g && i_opcode == 9'h007 |=>
        o_acc == m_q - 4'h1 && o_status == (m_q != 4'h0)) else $error("dec");
    a_dec_ptr: assert property (g && i_opcode == 9'h004 |=>
        o_ptr == y_q - 4'h1 && o_status == (o_ptr != 4'hf))
        else $error("dec ptr");
    a_add_ptr: assert property (g && i_opcode[8:4] == 5'h0f |=>
        o_ptr == y_q + k_q && o_status) else $error("add ptr");
    a_negate: assert property (g && i_opcode == 9'h031 |=>
        o_acc == 4'h0 - a_q && o_status == (a_q == 4'h0)) else $error("neg");
    a_inc_ptr: assert property (g && i_opcode == 9'h005 |=>
        o_ptr == y_q + 4'h1 && o_status == (o_ptr == 4'h0))
        else $error("inc ptr");
    a_unknown_quiet: assert property (i_ce && i_opcode[8] |=> !o_done)
        else $error("unknown code pulsed done");
    a_freeze_hold: assert property (!i_ce |=> $stable(o_acc) &&
        $stable(o_ptr) && $stable(o_status) && $stable(o_done))
        else $error("freeze moved state");
    // Main scenarios
    c_chain: cover property (g ##1 g ##1 o_done);
    c_freeze: cover property (o_done && !i_ce);
    c_wrap: cover property (g && i_opcode == 9'h005 ##1 o_status);
endmodule // nau_unit_properties
bind nau_unit nau_unit_properties u_props (.i_core_clk, .i_rst_n, .i_ce,
    .i_exec, .i_opcode, .i_mem_nib, .o_acc, .o_ptr, .o_status, .o_done);
`default_nettype wire

// [tb/nau_unit_test.sv]
// Bench for the nibble arithmetic unit
`timescale 1ns/1ps
`default_nettype none
module nau_unit_test;
    import nau_pkg::*;
    logic clk, rst_n, ce, ex, done, st, s, e;
    nau_op_t op, o;
    nau_nib_t mem, acc, ptr, a, y;
    logic [8:0] q[$];
    int error_cnt, checks_done, cyc;
    nau_op_t tbl[9] = '{9'h070, 9'h015, 9'h030, 9'h032, 9'h007, 9'h005,
        9'h004, 9'h0f0, 9'h031};
    nau_unit DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_exec(ex), .i_opcode(op), .i_mem_nib(mem), .o_acc(acc),
        .o_ptr(ptr), .o_status(st), .o_done(done));
    // Core clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counts and verdict
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare registers against a note
    task automatic chk(input logic [8:0] x, input logic [8:0] v);
        checks_done++;
        error_cnt += int'(v !== x);
        if (v !== x)
            $display("BAD regs exp %h got %h", x, v);
    endtask
    // Drive one cycle and note the expected registers
    task automatic run(input nau_op_t p, input nau_nib_t m,
        input logic [1:0] c);
        @(posedge clk);
        #1;
        {ce, ex, op, mem} = {c, p, m};
        if (c != 2'b11)
            return;
        casez (p)
            9'h07?: {s, a} = a + p[3:0];
            9'h015: {s, a} = a + m;
            9'h030: {s, a} = {a <= m, m - a};
            9'h032: {s, a} = m + 5'h01;
            9'h007: {s, a} = {m != 4'h0, m - 4'h1};
            9'h005: {s, y} = {y == 4'hf, y + 4'h1};
            9'h004: {s, y} = {y != 4'h0, y - 4'h1};
            9'h0f?: {s, y} = {1'b1, y + p[3:0]};
            9'h031: {s, a} = {a == 4'h0, 4'h0 - a};
            default: return;
        endcase
        q.push_back({a, y, s});
    endtask
    // Check each done pulse against the oldest note; bound the run
    always @(posedge clk)
    begin
        e = ce;
        cyc++;
        if (cyc > 3000)
            error_cnt++;
        if (cyc > 3000)
            tally_and_finish;
        #2;
        if (done === 1'b1 && e === 1'b1)
        begin
            if (q.size() == 0)
                q.push_back('x);
            chk(q.pop_front(), {acc, ptr, st});
        end
    end
    // Reset, then random opcodes with freezes, idles and unknown codes
    initial
    begin
        {rst_n, ce, ex, op, mem, a, y, s} = '0;
        void'($urandom(32'h3b44c2ff));
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (600)
        begin
            o = tbl[$urandom_range(8)];
            o[3:0] = o[6:4] == 3'h7 ? 4'($urandom) : o[3:0];
            o[8] = $urandom_range(15) == 0;
            run(o, 4'($urandom), $urandom_range(3) ? 2'b11 : 2'($urandom));
        end
        run(9'h000, 4'h0, 2'b10);
        run(9'h000, 4'h0, 2'b10);
        chk(9'h000, 9'(q.size()));
        tally_and_finish;
    end
endmodule // nau_unit_test
`default_nettype wire
